// ### rtl/pcfe_top.sv
// Behaviour
// - Fixed-function bit low connects, high disconnects
// - Debug data and reset bits reset enabled
// - Bits 10..21 attach converter channels 0..11
// - Pull field selects none/down/up/repeater, resets up
// - Repeater pulls toward current pin level
// - Bit 5 hysteresis, bit 6 inverts input
// - Bit 10 pseudo open-drain, resets off
// - Pad reset 0xb0, pins 7,8 0x90
// - Analog fixed function puts pad analog
// - Pins default to general-purpose function, except pins 2 and 5
// - One configuration register per port pin
// - Unbonded pin registers behave as reserved
//
// Decided for this implementation: register access over AHB-Lite.
module pcfe_top #(
	parameter logic [17:0] PIN_BONDED = 18'h3ffbf
) (
	// System
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Pads
	input  wire logic [17:0] pin_level,
	output logic      [17:0] pull_up_en,
	output logic      [17:0] pull_down_en,
	output logic      [17:0] hyst_en,
	output logic      [17:0] pseudo_open_drain_enable,
	output logic      [17:0] analog_en,
	output logic      [17:0] gpio_sel,
	output logic      [17:0] pin_data,
	// Fixed functions, high while connected to their pin
	output logic      [21:0] fn_connect
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [17:0][1:0] mode;
		logic [17:0]      hysteresis_enable;
		logic [17:0]      input_invert;
		logic [17:0]      od;
		logic [21:0]      ffe;
		logic             wr_pend;
		logic             wr_ffe;
		logic [4:0]       wr_pin;
		logic [17:0]      sync1;
		logic [17:0]      sync2;
		logic [31:0]      rdata;
		logic             ready;
		logic [17:0]      pu;
		logic [17:0]      pd;
		logic [17:0]      hy;
		logic [17:0]      odo;
		logic [17:0]      ana;
		logic [17:0]      gpio;
		logic [17:0]      din;
		logic [21:0]      conn;
	} pcfe_state_s;

	pcfe_state_s s;
	pcfe_state_s next_s;

	// Each bonded port pin owns exactly one word; unknown offsets map to no pin.
	function automatic logic [4:0] pad_index(input logic [11:0] ofs);
		case (ofs)
			pcfe_pkg::OFS_PAD_CFG_0:  pad_index = 5'd0;
			pcfe_pkg::OFS_PAD_CFG_1:  pad_index = 5'd1;
			pcfe_pkg::OFS_PAD_CFG_2:  pad_index = 5'd2;
			pcfe_pkg::OFS_PAD_CFG_3:  pad_index = 5'd3;
			pcfe_pkg::OFS_PAD_CFG_4:  pad_index = 5'd4;
			pcfe_pkg::OFS_PAD_CFG_5:  pad_index = 5'd5;
			pcfe_pkg::OFS_PAD_CFG_7:  pad_index = 5'd7;
			pcfe_pkg::OFS_PAD_CFG_8:  pad_index = 5'd8;
			pcfe_pkg::OFS_PAD_CFG_9:  pad_index = 5'd9;
			pcfe_pkg::OFS_PAD_CFG_10: pad_index = 5'd10;
			pcfe_pkg::OFS_PAD_CFG_11: pad_index = 5'd11;
			pcfe_pkg::OFS_PAD_CFG_12: pad_index = 5'd12;
			pcfe_pkg::OFS_PAD_CFG_13: pad_index = 5'd13;
			pcfe_pkg::OFS_PAD_CFG_14: pad_index = 5'd14;
			pcfe_pkg::OFS_PAD_CFG_15: pad_index = 5'd15;
			pcfe_pkg::OFS_PAD_CFG_16: pad_index = 5'd16;
			pcfe_pkg::OFS_PAD_CFG_17: pad_index = 5'd17;
			default:                  pad_index = pcfe_pkg::NO_PIN;
		endcase
	endfunction : pad_index

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [4:0]  p;
		logic [11:0] ofs;
		logic        used;
		logic        anl;
		p = pcfe_pkg::NO_PIN;
		ofs = haddr[11:0];
		used = 1'b0;
		anl = 1'b0;
		next_s = s;
		next_s.ready = 1'b1;
		next_s.sync1 = pin_level;
		next_s.sync2 = s.sync1;
		next_s.wr_pend = 1'b0;

		// Data phase of a write taken in the previous cycle.
		if (s.wr_pend) begin
			if (s.wr_ffe) begin
				next_s.ffe = hwdata[21:0];
			end else if (s.wr_pin != pcfe_pkg::NO_PIN && PIN_BONDED[s.wr_pin]) begin
				next_s.mode[s.wr_pin] = hwdata[pcfe_pkg::MODE_LSB +: 2];
				next_s.hysteresis_enable[s.wr_pin] = hwdata[pcfe_pkg::HYS_BIT];
				next_s.input_invert[s.wr_pin] = hwdata[pcfe_pkg::INV_BIT];
				next_s.od[s.wr_pin] = hwdata[pcfe_pkg::OD_BIT];
			end
		end

		// Address phase. Reads look at the post-write image so that a read right
		// behind a write to the same word returns the new value.
		if (hsel && htrans[1] && hready) begin
			p = pad_index(ofs);
			next_s.wr_pend = hwrite;
			next_s.wr_pin = p;
			next_s.wr_ffe = (ofs == pcfe_pkg::OFS_FFE);
			if (!hwrite) begin
				next_s.rdata = 32'h0000_0000;
				if (ofs == pcfe_pkg::OFS_FFE) begin
					next_s.rdata[21:0] = next_s.ffe;
				end else if (p != pcfe_pkg::NO_PIN && PIN_BONDED[p]) begin
					next_s.rdata[pcfe_pkg::MODE_LSB +: 2] = next_s.mode[p];
					next_s.rdata[pcfe_pkg::HYS_BIT] = next_s.hysteresis_enable[p];
					next_s.rdata[pcfe_pkg::INV_BIT] = next_s.input_invert[p];
					next_s.rdata[pcfe_pkg::ONE_BIT] = 1'b1;
					next_s.rdata[pcfe_pkg::OD_BIT] = next_s.od[p];
				end else if (p != pcfe_pkg::NO_PIN) begin
					next_s.rdata = pcfe_pkg::HYS_RESET[p] ? pcfe_pkg::PAD_RESET
						: pcfe_pkg::PAD_RESET_NOHYS;
				end else if (ofs == pcfe_pkg::OFS_RSV_030) begin
					next_s.rdata = pcfe_pkg::PAD_RESET;
				end
			end
		end

		// Pad controls, one pass per pin.
		for (int i = 0; i < pcfe_pkg::NUM_PINS; i++) begin
			used = 1'b0;
			anl = 1'b0;
			for (int f = 0; f < pcfe_pkg::NUM_FUNCS; f++) begin
				if (pcfe_pkg::FUNC_PIN[f] == 5'(i) && !next_s.ffe[f]) begin
					used = 1'b1;
					anl = anl | pcfe_pkg::FFE_ANALOG[f];
				end
			end
			// The pull-up stays as programmed in analog mode; software must drop it.
			next_s.pu[i] = (next_s.mode[i] == pcfe_pkg::PULL_UP)
				|| (next_s.mode[i] == pcfe_pkg::PULL_REPEAT && s.sync2[i]);
			next_s.pd[i] = (next_s.mode[i] == pcfe_pkg::PULL_DOWN)
				|| (next_s.mode[i] == pcfe_pkg::PULL_REPEAT && !s.sync2[i]);
			next_s.hy[i] = next_s.hysteresis_enable[i];
			next_s.odo[i] = next_s.od[i];
			next_s.ana[i] = anl;
			next_s.gpio[i] = !used;
			next_s.din[i] = s.sync2[i] ^ next_s.input_invert[i];
		end
		next_s.conn = ~next_s.ffe;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s <= '0;
			s.ready <= 1'b1;
			s.wr_pin <= pcfe_pkg::NO_PIN;
			s.mode <= {pcfe_pkg::NUM_PINS{pcfe_pkg::PULL_UP}};
			s.hysteresis_enable <= pcfe_pkg::HYS_RESET;
			s.ffe <= pcfe_pkg::FFE_RESET;
			s.pu <= 18'h3ffff;
			s.hy <= pcfe_pkg::HYS_RESET;
			s.gpio <= 18'h3ffdb;
			s.conn <= ~pcfe_pkg::FFE_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign hrdata = s.rdata;
	assign hreadyout = s.ready;
	assign hresp = 1'b0;
	assign pull_up_en = s.pu;
	assign pull_down_en = s.pd;
	assign hyst_en = s.hy;
	assign pseudo_open_drain_enable = s.odo;
	assign analog_en = s.ana;
	assign gpio_sel = s.gpio;
	assign pin_data = s.din;
	assign fn_connect = s.conn;

endmodule : pcfe_top

// ### rtl/pcfe_pkg.sv
package pcfe_pkg;

	// ----------------------------------------------------------------
	// Geometry
	// ----------------------------------------------------------------
	localparam int             NUM_PINS   = 18;
	localparam int             NUM_FUNCS  = 22;
	localparam logic [4:0]     NO_PIN     = 5'h1f;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [11:0]    OFS_PAD_CFG_17 = 12'h000;
	localparam logic [11:0]    OFS_PAD_CFG_13 = 12'h004;
	localparam logic [11:0]    OFS_PAD_CFG_12 = 12'h008;
	localparam logic [11:0]    OFS_PAD_CFG_5  = 12'h00c;
	localparam logic [11:0]    OFS_PAD_CFG_4  = 12'h010;
	localparam logic [11:0]    OFS_PAD_CFG_3  = 12'h014;
	localparam logic [11:0]    OFS_PAD_CFG_2  = 12'h018;
	localparam logic [11:0]    OFS_PAD_CFG_11 = 12'h01c;
	localparam logic [11:0]    OFS_PAD_CFG_10 = 12'h020;
	localparam logic [11:0]    OFS_PAD_CFG_16 = 12'h024;
	localparam logic [11:0]    OFS_PAD_CFG_15 = 12'h028;
	localparam logic [11:0]    OFS_PAD_CFG_1  = 12'h02c;
	localparam logic [11:0]    OFS_RSV_030    = 12'h030;
	localparam logic [11:0]    OFS_PAD_CFG_9  = 12'h034;
	localparam logic [11:0]    OFS_PAD_CFG_8  = 12'h038;
	localparam logic [11:0]    OFS_PAD_CFG_7  = 12'h03c;
	localparam logic [11:0]    OFS_RSV_040    = 12'h040;
	localparam logic [11:0]    OFS_PAD_CFG_0  = 12'h044;
	localparam logic [11:0]    OFS_PAD_CFG_14 = 12'h048;
	localparam logic [11:0]    OFS_FFE        = 12'h1c0;

	// ----------------------------------------------------------------
	// Pad register fields and reset values
	// ----------------------------------------------------------------
	localparam int             MODE_LSB   = 3;
	localparam int             HYS_BIT    = 5;
	localparam int             INV_BIT    = 6;
	localparam int             ONE_BIT    = 7;
	localparam int             OD_BIT     = 10;
	localparam logic [31:0]    PAD_RESET       = 32'h0000_00b0;
	localparam logic [31:0]    PAD_RESET_NOHYS = 32'h0000_0090;
	localparam logic [17:0]    HYS_RESET  = 18'h3fe7f;

	typedef enum logic [1:0] {
		PULL_NONE   = 2'b00,
		PULL_DOWN   = 2'b01,
		PULL_UP     = 2'b10,
		PULL_REPEAT = 2'b11
	} pcfe_pull_e;

	// ----------------------------------------------------------------
	// Fixed-function enable: reset, analog functions, pin of each bit
	// ----------------------------------------------------------------
	localparam logic [21:0]    FFE_RESET  = 22'h3fff9f;
	localparam logic [21:0]    FFE_ANALOG = 22'h3ffe0f;
	localparam logic [4:0]     FUNC_PIN [0:21] = '{
		5'h00, 5'h01, 5'h0e, 5'h10, 5'h03, 5'h02, 5'h05, 5'h01,
		5'h0b, 5'h07, 5'h01, 5'h07, 5'h0e, 5'h10, 5'h09, 5'h08,
		5'h0b, 5'h0a, 5'h0f, 5'h11, 5'h0d, 5'h04
	};

endpackage : pcfe_pkg

// ### testbench/pcfe_monitor.sv
module pcfe_monitor (
	// System
	input wire logic        clk_sys,
	input wire logic        rst_n,
	// Bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// Pads and functions
	input wire logic [17:0] pin_level,
	input wire logic [17:0] pull_up_en,
	input wire logic [17:0] pull_down_en,
	input wire logic [17:0] pin_data,
	input wire logic [17:0] analog_en,
	input wire logic [17:0] gpio_sel,
	input wire logic [21:0] fn_connect
);
	logic        tk;
	logic [11:0] ofs;
	logic [17:0] used;
	logic [17:0] anl;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	assign tk = hsel && htrans[1] && hready;
	assign ofs = haddr[11:0];
	always_comb begin
		used = '0;
		anl = '0;
		for (int f = 0; f < pcfe_pkg::NUM_FUNCS; f++) begin
			if (fn_connect[f]) begin
				used[pcfe_pkg::FUNC_PIN[f]] = 1'b1;
				anl[pcfe_pkg::FUNC_PIN[f]] = anl[pcfe_pkg::FUNC_PIN[f]] | pcfe_pkg::FFE_ANALOG[f];
			end
		end
	end
	sequence s_ffe_wr;
		tk && hwrite && ofs == pcfe_pkg::OFS_FFE ##1 1'b1;
	endsequence
	// Six quiet edges outlast the synchroniser and output register.
	sequence s_quiet;
		(!tk && $stable(pin_level)) [*6];
	endsequence
	chk_always_ready: assert property (hreadyout) else $error("wait state inserted");
	chk_resp_okay: assert property (!hresp) else $error("error response");
	chk_pull_excl: assert property ((pull_up_en & pull_down_en) == 18'h0)
		else $error("pull up and down together");
	chk_gpio_free: assert property (gpio_sel == ~used) else $error("gpio select wrong");
	chk_analog_pad: assert property (analog_en == anl) else $error("analog pad wrong");
	chk_ffe_write: assert property (
		s_ffe_wr |=> {10'h0, ~fn_connect} == ($past(hwdata) & 32'h3fffff)
	) else $error("function connect wrong after write");
	chk_ffe_read: assert property (
		tk && !hwrite && ofs == pcfe_pkg::OFS_FFE |=> hrdata == {10'h0, ~fn_connect}
	) else $error("function enable read wrong");
	chk_pad_fixed: assert property (
		tk && !hwrite && ofs < 12'h04c && ofs != pcfe_pkg::OFS_RSV_040
		|=> (hrdata & 32'hfffffb87) == 32'h80
	) else $error("pad reserved bits wrong");
	chk_quiet_hold: assert property (
		s_quiet |-> $stable(pin_data) && $stable(pull_up_en) && $stable(pull_down_en)
	) else $error("pad output moved while quiet");
endmodule : pcfe_monitor

bind pcfe_top pcfe_monitor i_pcfe_monitor (
	.clk_sys, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
	.hreadyout, .hresp, .pin_level, .pull_up_en, .pull_down_en, .pin_data,
	.analog_en, .gpio_sel, .fn_connect
);

// ### testbench/pcfe_top_tb.sv
module pcfe_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	// Pin 6 has no pad, so its slot points at the reserved word.
	localparam logic [11:0] OFS [0:17] = '{
		12'h044, 12'h02c, 12'h018, 12'h014, 12'h010, 12'h00c, 12'h030, 12'h03c, 12'h038,
		12'h034, 12'h020, 12'h01c, 12'h008, 12'h004, 12'h048, 12'h028, 12'h024, 12'h000
	};
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic        hsel = 1'b1;
	logic [31:0] haddr = '0;
	logic [1:0]  htrans = '0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = '0;
	logic [17:0] pin_level = '0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [17:0] pu, pd, hy, od, an, gs, pdat;
	logic [21:0] fc;
	logic [31:0] pad [0:17];
	logic [21:0] ffe;
	logic [31:0] rd, d;
	int          fail_count = 0;
	int          checks_done = 0;
	int          cyc = 0;
	int          p;
	// The block's clock runs free for the whole run, toggling every 50 ns.
	always #50 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			end_of_test();
		end
	end
	pcfe_top i_pcfe_top (
		.clk_sys, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .pin_level,
		.pull_up_en(pu), .pull_down_en(pd), .hyst_en(hy), .pseudo_open_drain_enable(od),
		.analog_en(an), .gpio_sel(gs), .pin_data(pdat), .fn_connect(fc)
	);
	task chk(input logic [159:0] g, input logic [159:0] e);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task xfer(input logic [11:0] a, input logic w, input logic [31:0] wd);
		haddr <= {20'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		@(posedge clk_sys);
		while (hreadyout !== 1'b1) @(posedge clk_sys);
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge clk_sys);
		while (hreadyout !== 1'b1) @(posedge clk_sys);
		rd = hrdata;
	endtask : xfer
	task rdchk(input logic [11:0] a, input logic [31:0] e);
		xfer(a, 1'b0, 32'h0);
		chk(rd, e);
	endtask : rdchk
	task cmp_pads;
		logic [17:0] eu, ed, eh, eo, ea, eg, ep;
		{eu, ed, eh, eo, ea, ep} = '0;
		eg = '1;
		for (int i = 0; i < 18; i++) begin
			eu[i] = pad[i][4:3] == 2'h2 || (pad[i][4:3] == 2'h3 && pin_level[i]);
			ed[i] = pad[i][4:3] == 2'h1 || (pad[i][4:3] == 2'h3 && !pin_level[i]);
			eh[i] = pad[i][5];
			eo[i] = pad[i][10];
			ep[i] = pin_level[i] ^ pad[i][6];
		end
		for (int f = 0; f < 22; f++) begin
			if (!ffe[f]) begin
				eg[pcfe_pkg::FUNC_PIN[f]] = 1'b0;
				ea[pcfe_pkg::FUNC_PIN[f]] = ea[pcfe_pkg::FUNC_PIN[f]] | pcfe_pkg::FFE_ANALOG[f];
			end
		end
		chk({fc, pu, pd, hy, od, an, gs, pdat & 18'h3ffbf},
			{~ffe, eu, ed, eh, eo, ea, eg, ep & 18'h3ffbf});
	endtask : cmp_pads
	task end_of_test;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_of_test
	initial begin
		void'($urandom(32'h43cc));
		for (int i = 0; i < 18; i++) begin
			pad[i] = (i == 7 || i == 8) ? pcfe_pkg::PAD_RESET_NOHYS : pcfe_pkg::PAD_RESET;
		end
		ffe = pcfe_pkg::FFE_RESET;
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		cmp_pads();
		for (int i = 0; i < 18; i++) begin
			rdchk(OFS[i], pad[i]);
		end
		rdchk(12'h040, 32'h0);
		rdchk(12'h100, 32'h0);
		rdchk(12'h1c0, {10'h0, ffe});
		$display("test reset done");
		repeat (60) begin
			p = $urandom_range(17);
			d = $urandom;
			xfer(OFS[p], 1'b1, d);
			if (p != 6) begin
				pad[p] = (d & 32'h478) | 32'h80;
			end
			rdchk(OFS[p], pad[p]);
			pin_level <= d[31:14];
			// Four edges cover the two synchroniser stages and the output register.
			repeat (4) @(posedge clk_sys);
			cmp_pads();
		end
		xfer(12'h040, 1'b1, $urandom);
		rdchk(12'h040, 32'h0);
		$display("test pads done");
		for (int f = 0; f < 32; f++) begin
			d = f < 22 ? ~(32'h1 << f) : $urandom;
			xfer(12'h1c0, 1'b1, d);
			ffe = d[21:0];
			rdchk(12'h1c0, {10'h0, ffe});
			cmp_pads();
			// Software drops the pull-up itself once a pin carries an analog function.
			if (f < 22 && pcfe_pkg::FFE_ANALOG[f]) begin
				p = int'(pcfe_pkg::FUNC_PIN[f]);
				pad[p] = pad[p] & ~32'h0000_0018;
				xfer(OFS[p], 1'b1, pad[p]);
				@(posedge clk_sys);
				cmp_pads();
			end
		end
		$display("test functions done");
		end_of_test();
	end
endmodule : pcfe_top_tb
